// ===== hw/fpd_ctrl.sv
// Controller that drives a 1M x 16 fast-page DRAM through its pins.
//
// Overview of operation
// - Lower byte write: lower strobe low, upper high, write low, gate high.
// - Upper byte write: upper strobe low, lower high, write low, gate high.
// - Word write: both column strobes low, write low, gate high.
// - Issue 1024 refreshes, covering every row, in each 16 ms.
// - After power-up wait 200 us, then at least eight refresh cycles.
// - Row address is set before row strobe falls and held after it; the start-up row-only refreshes change it on the same edge.
`timescale 1ns/10ps
module fpd_ctrl
  import fpd_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_CYC,
  parameter int REFRESH_GAP = REFRESH_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire fpd_req_s req_data,
  input wire logic req_valid,
  output logic req_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic ready_for_use,
  output fpd_pins_s pins,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic [1:0] data_lines_oe
);

  initial begin
    // The wait counter is 18 bits and the refresh timer 16 bits wide.
    if (POWERUP_WAIT < 1 || POWERUP_WAIT > 262144 || REFRESH_GAP < 8 || REFRESH_GAP > 65535) begin
      $error("fpd_ctrl: timing parameters out of range");
    end
  end

  // ----------------------------------------------------------------
  // Request buffering
  // ----------------------------------------------------------------
  fpd_req_s head;
  logic head_valid;
  logic head_pop;

  fpd_fifo #(.WIDTH($bits(fpd_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(req_data),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(head_pop)
  );

  // ----------------------------------------------------------------
  // Data lines are sampled through two flip-flops
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dq_meta_ff;
  logic [DATA_W-1:0] dq_sync_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_meta_ff <= '0;
      dq_sync_ff <= '0;
    end else begin
      dq_meta_ff <= data_lines_in;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  fpd_state_e state_ff;
  logic [17:0] wait_ff;
  logic [3:0] init_cnt_ff;
  logic [15:0] ref_timer_ff;
  logic ref_due_ff;
  fpd_req_s cur_ff;
  logic [1:0] sync_wait_ff;
  logic ref_start;

  assign ref_start = (state_ff == ST_IDLE) && ref_due_ff;
  // Refresh wins over a waiting access, so no row ever misses its slot.
  assign head_pop = (state_ff == ST_IDLE) && !ref_due_ff && head_valid;

  // Refresh interval timer; a request from the timer stays pending until served.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_timer_ff <= '0;
      ref_due_ff <= 1'b0;
    end else begin
      if (ref_timer_ff == 16'(REFRESH_GAP - 1)) begin
        ref_timer_ff <= '0;
      end else begin
        ref_timer_ff <= ref_timer_ff + 1'b1;
      end
      if (ref_timer_ff == 16'(REFRESH_GAP - 1)) begin
        ref_due_ff <= 1'b1;
      end else if (ref_start) begin
        ref_due_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_POWERUP;
      wait_ff <= '0;
      init_cnt_ff <= '0;
      cur_ff <= '0;
      sync_wait_ff <= '0;
    end else begin
      case (state_ff)
        ST_POWERUP: begin
          if (wait_ff == 18'(POWERUP_WAIT - 1)) begin
            state_ff <= ST_INIT_LOW;
          end else begin
            wait_ff <= wait_ff + 1'b1;
          end
        end
        ST_INIT_LOW: begin
          state_ff <= ST_INIT_HIGH;
        end
        ST_INIT_HIGH: begin
          init_cnt_ff <= init_cnt_ff + 1'b1;
          if (init_cnt_ff == 4'(INIT_CYCLES - 1)) begin
            state_ff <= ST_IDLE;
          end else begin
            state_ff <= ST_INIT_LOW;
          end
        end
        ST_IDLE: begin
          if (ref_due_ff) begin
            state_ff <= ST_REF_CAS;
          end else if (head_valid) begin
            cur_ff <= head;
            state_ff <= ST_ROW;
          end
        end
        ST_ROW: begin
          state_ff <= ST_COL;
        end
        ST_COL: begin
          sync_wait_ff <= '0;
          state_ff <= ST_DATA;
        end
        ST_DATA: begin
          // Reads hold the column strobes until the synchroniser has the data.
          if (cur_ff.wr || sync_wait_ff == 2'd2) begin
            state_ff <= ST_PRECHARGE;
          end else begin
            sync_wait_ff <= sync_wait_ff + 1'b1;
          end
        end
        ST_PRECHARGE: begin
          state_ff <= ST_IDLE;
        end
        ST_REF_CAS: begin
          state_ff <= ST_REF_RAS;
        end
        ST_REF_RAS: begin
          state_ff <= ST_REF_END;
        end
        ST_REF_END: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, all from flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 10'h000};
      data_lines_out <= '0;
      data_lines_oe <= 2'b00;
    end else begin
      pins.row_strobe_n <= 1'b1;
      pins.low_lane_col_strobe_n <= 1'b1;
      pins.high_lane_col_strobe_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      pins.out_gate_n <= 1'b1;
      data_lines_oe <= 2'b00;
      case (state_ff)
        ST_INIT_LOW: begin
          // Row-only refresh for the start-up cycles.
          pins.row_strobe_n <= 1'b0;
          pins.addr_lines <= {6'h00, init_cnt_ff};
        end
        ST_IDLE: begin
          if (ref_due_ff) begin
            // Column strobes lead the row strobe, so the memory uses its own row counter.
            pins.low_lane_col_strobe_n <= 1'b0;
            pins.high_lane_col_strobe_n <= 1'b0;
          end else if (head_valid) begin
            pins.addr_lines <= head.addr[19:10];
          end
        end
        ST_ROW: begin
          pins.row_strobe_n <= 1'b0;
          pins.write_strobe_n <= !cur_ff.wr;
          data_lines_out <= cur_ff.wdata;
        end
        ST_COL, ST_DATA: begin
          // One column pulse per opened row; page bursts are never issued.
          pins.row_strobe_n <= 1'b0;
          pins.addr_lines <= cur_ff.addr[9:0];
          pins.low_lane_col_strobe_n <= !cur_ff.lanes[0];
          pins.high_lane_col_strobe_n <= !cur_ff.lanes[1];
          pins.write_strobe_n <= !cur_ff.wr;
          pins.out_gate_n <= cur_ff.wr;
          if (cur_ff.wr) begin
            data_lines_oe <= cur_ff.lanes;
          end
          if (state_ff == ST_DATA && (cur_ff.wr || sync_wait_ff == 2'd2)) begin
            pins.low_lane_col_strobe_n <= 1'b1;
            pins.high_lane_col_strobe_n <= 1'b1;
            pins.out_gate_n <= 1'b1;
            pins.write_strobe_n <= 1'b1;
            data_lines_oe <= 2'b00;
          end
        end
        ST_REF_CAS: begin
          pins.low_lane_col_strobe_n <= 1'b0;
          pins.high_lane_col_strobe_n <= 1'b0;
        end
        ST_REF_RAS: begin
          pins.row_strobe_n <= 1'b0;
          pins.low_lane_col_strobe_n <= 1'b0;
          pins.high_lane_col_strobe_n <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read return and readiness
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
      ready_for_use <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state_ff == ST_DATA && !cur_ff.wr && sync_wait_ff == 2'd2) begin
        rd_data[7:0] <= cur_ff.lanes[0] ? dq_sync_ff[7:0] : 8'h00;
        rd_data[15:8] <= cur_ff.lanes[1] ? dq_sync_ff[15:8] : 8'h00;
        rd_valid <= 1'b1;
      end
      if (state_ff == ST_IDLE) begin
        ready_for_use <= 1'b1;
      end
    end
  end

endmodule

// ===== include/fpd_pkg.sv
// Package for the fast-page DRAM controller: constants, timing and carrier types.
package fpd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int ROWS = 1024;

  // ----------------------------------------------------------------
  // Timing (clock 25 MHz, 40 ns period)
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int POWERUP_US = 200;
  localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_MS = 16;
  localparam int REFRESH_ROWS = 1024;
  // Longest spacing between refreshes, rounded down.
  localparam int REFRESH_CYC = (REFRESH_MS * 1000000 / REFRESH_ROWS) / CLK_NS;
  localparam int INIT_CYCLES = 8;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [1:0] lanes;
    logic [19:0] addr;
    logic [15:0] wdata;
  } fpd_req_s;

  typedef struct packed {
    logic row_strobe_n;
    logic low_lane_col_strobe_n;
    logic high_lane_col_strobe_n;
    logic write_strobe_n;
    logic out_gate_n;
    logic [9:0] addr_lines;
  } fpd_pins_s;

  typedef enum logic [3:0] {
    ST_POWERUP, ST_INIT_LOW, ST_INIT_HIGH, ST_IDLE, ST_ROW, ST_COL,
    ST_DATA, ST_PRECHARGE, ST_REF_CAS, ST_REF_RAS, ST_REF_END
  } fpd_state_e;

endpackage

// ===== hw/fpd_fifo.sv
// Request FIFO for the DRAM controller, flip-flop storage.
`timescale 1ns/10ps
module fpd_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("fpd_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// ===== verif/fpd_chk_assertions.sv
// Concurrent checks on the DRAM pin sequencing of fpd_ctrl.
`timescale 1ns/10ps
module fpd_chk
  import fpd_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_CYC,
  parameter int REFRESH_GAP = REFRESH_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd_valid,
  input wire logic ready_for_use,
  input wire fpd_pins_s pins,
  input wire logic [1:0] data_lines_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic ras_n, lo_n, hi_n, we_n, gate_n, ras_d_ff, ras_fall;
  logic [31:0] wait_ff, init_ff, gap_ff;
  assign ras_n = pins.row_strobe_n;
  assign lo_n = pins.low_lane_col_strobe_n;
  assign hi_n = pins.high_lane_col_strobe_n;
  assign we_n = pins.write_strobe_n;
  assign gate_n = pins.out_gate_n;
  assign ras_fall = ras_d_ff && !ras_n;
  // The wait counter saturates so a long idle run cannot wrap it back to a failing value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ras_d_ff <= 1'b1;
      wait_ff <= '0;
      init_ff <= '0;
      gap_ff <= '0;
    end else begin
      ras_d_ff <= ras_n;
      wait_ff <= (wait_ff < 32'h000fffff) ? wait_ff + 1 : wait_ff;
      init_ff <= (ras_fall && !ready_for_use) ? init_ff + 1 : init_ff;
      gap_ff <= (!ready_for_use || (ras_fall && !lo_n && !hi_n)) ? '0 : gap_ff + 1;
    end
  end
  sequence s_cas_first;
    ras_n && !lo_n && !hi_n;
  endsequence
  sequence s_both_low;
    !ras_n && !lo_n && !hi_n;
  endsequence
  a_powerup_wait: assert property (ras_fall && init_ff == 0 |-> wait_ff >= POWERUP_WAIT - 1)
    else $error("row strobe fell before the power-up wait");
  a_init_count: assert property ($rose(ready_for_use) |-> init_ff >= INIT_CYCLES)
    else $error("ready before eight init cycles");
  a_refresh_gap: assert property (ready_for_use |-> gap_ff <= REFRESH_GAP + 16)
    else $error("refresh interval exceeded");
  a_read_hands_off: assert property (!gate_n |-> data_lines_oe == 2'b00)
    else $error("controller drives lanes while output gate is low");
  a_write_lanes: assert property (data_lines_oe != 2'b00 |->
    !ras_n && !we_n && gate_n && data_lines_oe == ~{hi_n, lo_n})
    else $error("driven lanes do not match a write cycle");
  a_early_write: assert property (($fell(lo_n) || $fell(hi_n)) && !ras_n && !we_n |-> !$past(we_n))
    else $error("write strobe fell after the column strobe");
  a_cbr_order: assert property (s_cas_first ##1 s_both_low |-> ##[1:3] (ras_n && lo_n && hi_n))
    else $error("refresh strobes not released");
  a_cas_leads: assert property ($fell(ras_n) && !lo_n |-> !$past(lo_n) && !$past(hi_n))
    else $error("column strobe did not lead the row strobe");
  a_row_setup: assert property (ready_for_use && $fell(ras_n) && lo_n && hi_n |-> $stable(pins.addr_lines))
    else $error("row address changed with the row strobe");
  a_col_hold: assert property (($fell(lo_n) || $fell(hi_n)) && !ras_n |=> $stable(pins.addr_lines))
    else $error("column address not held");
  a_read_pulse: assert property (rd_valid |->
    (!$past(gate_n) || !$past(gate_n, 2) || !$past(gate_n, 3) || !$past(gate_n, 4)) ##1 !rd_valid)
    else $error("read result without a read cycle");
endmodule

bind fpd_ctrl fpd_chk #(.POWERUP_WAIT(POWERUP_WAIT), .REFRESH_GAP(REFRESH_GAP)) u_chk (
  .core_clk(core_clk), .rst(rst), .rd_valid(rd_valid), .ready_for_use(ready_for_use),
  .pins(pins), .data_lines_oe(data_lines_oe));

// ===== verif/fpd_dram_model.sv
// Behavioural model of the 1M x 16 fast-page DRAM at the pins.
`timescale 1ns/10ps
module fpd_dram_model
  import fpd_pkg::*;
(
  input wire logic core_clk,
  input wire fpd_pins_s pins,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [1:0] dq_oe,
  output int n_ref
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] rd_ff, w;
  logic [DATA_W-1:0] idle_ff = 16'h5aa5;
  logic [ADDR_W-1:0] row_ff, ctr_ff;
  logic [1:0] cas;
  int key;
  initial begin
    n_ref = 0;
    ctr_ff = '0;
  end
  assign cas = ~{pins.high_lane_col_strobe_n, pins.low_lane_col_strobe_n};
  // Released lanes toggle every cycle so a stale capture cannot pass.
  always @(posedge core_clk) idle_ff <= ~idle_ff;
  assign dq_oe = (!pins.row_strobe_n && pins.write_strobe_n && !pins.out_gate_n) ? cas :
    2'b00;
  assign dq_out = {dq_oe[1] ? rd_ff[15:8] : idle_ff[15:8], dq_oe[0] ? rd_ff[7:0] : idle_ff[7:0]};
  always @(negedge pins.row_strobe_n) begin
    if (cas == 2'b11) begin
      ctr_ff = ctr_ff + 10'h001;
      n_ref = n_ref + 1;
    end else begin
      row_ff = pins.addr_lines;
    end
  end
  always @(negedge pins.low_lane_col_strobe_n or negedge pins.high_lane_col_strobe_n) begin
    #1;
    key = int'({row_ff, pins.addr_lines});
    w = mem.exists(key) ? mem[key] : 16'h0000;
    if (!pins.row_strobe_n && !pins.write_strobe_n) begin
      if (cas[0]) w[7:0] = dq_in[7:0];
      if (cas[1]) w[15:8] = dq_in[15:8];
      mem[key] = w;
    end
    rd_ff = w;
  end
endmodule

// ===== verif/fpd_ctrl_tb.sv
// Self-checking testbench for the fast-page DRAM controller.
`timescale 1ns/10ps
module fpd_ctrl_tb
  import fpd_pkg::*;
;
  localparam int RG = 64;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  fpd_req_s req_data = '0;
  logic req_ready, rd_valid, rdy;
  logic [15:0] rd_data, dl_in, dl_out, m_out;
  logic [1:0] dl_oe, m_oe;
  fpd_pins_s pins;
  int n_errors = 0;
  int n_compared = 0;
  int n_ref;
  logic [15:0] shadow [int];
  logic [15:0] exp_q [$];
  logic [19:0] at [8] = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00, 20'h00400, 20'h12345,
    20'h54321, 20'h0ff00};

  always #20 core_clk = ~core_clk;
  assign dl_in = {dl_oe[1] ? dl_out[15:8] : m_out[15:8], dl_oe[0] ? dl_out[7:0] : m_out[7:0]};
  fpd_ctrl #(.POWERUP_WAIT(20), .REFRESH_GAP(RG)) DUT (.core_clk(core_clk), .rst(rst),
    .req_data(req_data), .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .ready_for_use(rdy), .pins(pins), .data_lines_in(dl_in),
    .data_lines_out(dl_out), .data_lines_oe(dl_oe));
  fpd_dram_model u_mem (.core_clk(core_clk), .pins(pins), .dq_in(dl_in), .dq_out(m_out),
    .dq_oe(m_oe), .n_ref(n_ref));

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic push(input logic wr, input logic [1:0] ln, input logic [19:0] a,
    input logic [15:0] d);
    int n;
    logic [15:0] m;
    n = 0;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    req_data <= '{wr, ln, a, d};
    req_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 4000);
    if (req_ready !== 1'b1) begin
      n_errors++;
      $display("BAD req_ready expected 1 seen %b", req_ready);
    end
    if (wr)
      shadow[int'(a)] = (shadow[int'(a)] & ~m) | (d & m);
    else
      exp_q.push_back(shadow[int'(a)] & m);
  endtask

  always @(posedge core_clk) begin
    // Before the first reset edge both sides are still unknown.
    if (rst === 1'b0)
      chk("lane clash", 16'h0000, {14'h0, dl_oe & m_oe});
    if (rd_valid === 1'b1)
      chk("rd_data", exp_q.size() > 0 ? exp_q.pop_front() : 16'hdead, rd_data);
  end

  // ----
  // Scenarios
  // ----
  task automatic t_fill;
    for (int i = 0; i < 8; i++) push(1'b1, 2'b11, at[i], 16'h1111 * 16'(i + 1));
    req_valid <= 1'b0;
    @(negedge core_clk);
    chk("req_ready full", 16'h0000, {15'h0, req_ready});
    chk("ready early", 16'h0000, {15'h0, rdy});
    @(posedge core_clk);
    push(1'b0, 2'b11, at[0], 16'h0000);
    req_valid <= 1'b0;
    @(negedge core_clk);
    chk("ready late", 16'h0001, {15'h0, rdy});
    @(posedge core_clk);
    $display("t_fill done");
  endtask
  task automatic t_rw;
    int n;
    n = 0;
    push(1'b1, 2'b01, at[0], 16'hff56);
    push(1'b1, 2'b10, at[1], 16'h77ff);
    push(1'b1, 2'b11, at[2], 16'hc3a5);
    push(1'b1, 2'b00, at[3], 16'hbeef);
    push(1'b0, 2'b00, at[3], 16'h0000);
    for (int i = 0; i < 8; i++) begin
      for (int l = 1; l < 4; l++) push(1'b0, 2'(l), at[i], 16'h0000);
    end
    req_valid <= 1'b0;
    while (exp_q.size() > 0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk("reads left", 16'h0000, 16'(exp_q.size()));
    $display("t_rw done");
  endtask
  task automatic t_refresh;
    int n0;
    n0 = n_ref;
    repeat (3 * RG) @(posedge core_clk);
    chk("refreshes", 16'h0001, {15'h0, (n_ref - n0) >= 2});
    chk("lanes idle", 16'h0000, {14'h0, dl_oe | m_oe});
    $display("t_refresh done");
  endtask

  initial begin
    @(negedge core_clk);
    chk("pins in reset", 16'h7c00, {1'b0, pins});
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_fill();
    t_rw();
    t_refresh();
    end_of_test();
  end
  initial begin
    repeat (8000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end
endmodule
